// ### inc/rtc_pkg.sv
package rtc_pkg;
	// Run-time word layout and defaults
	localparam logic [15:0] RT_DEFAULT = 16'h7622;
	localparam int RT_LARGE_BIT = 15;
	localparam int RT_SMALL_BIT = 14;
	localparam int RT_CNT_W = 14;
	localparam int SMALL_SHIFT = 4;
	localparam int LARGE_SHIFT = 8;
	localparam int SCALED_W = RT_CNT_W + SMALL_SHIFT + LARGE_SHIFT;
	localparam logic [15:0] PP_DEFAULT = 16'h019A;
	// Telecommand header
	localparam int TC_WORDS = 7;
	localparam logic [15:0] HDR_ID_WORD = 16'h1C7C;
	localparam logic [1:0] SEQ_FLAGS = 2'h3;
	localparam logic [2:0] SEQ_SRC_GROUND = 3'h0;
	localparam logic [15:0] PKT_LEN = 16'h0007;
	localparam logic [3:0] PUS_CHK_NIB = 4'h1;
	localparam logic [3:0] ACK_RUN_TIME = 4'h1;
	localparam logic [3:0] ACK_PULSE_POS = 4'h9;
	localparam logic [7:0] PKT_TYPE = 8'hC0;
	localparam logic [7:0] SUB_RUN_TIME = 8'h0C;
	localparam logic [7:0] SUB_PULSE_POS = 8'h0D;
	localparam logic [7:0] PAD_BYTE = 8'h00;
	// Timing
	localparam int CLK_HZ = 20000000;
	localparam real SCAN_CYC_US = 22.35;
	localparam int SCAN_CYC_CLK = int'(SCAN_CYC_US * CLK_HZ / 1.0e6);
	localparam int MS_PER_S = 1000;
	localparam int MS_CYC_CLK = CLK_HZ / MS_PER_S;
	localparam real CONT_MIN_S = 4.95;
	localparam real CONT_MAX_S = 5.05;
	localparam int CONT_MIN_MS = int'($ceil(CONT_MIN_S * MS_PER_S));
	localparam int CONT_MAX_MS = int'($floor(CONT_MAX_S * MS_PER_S));
	localparam int CONT_READ_MS_DEF = (CONT_MIN_MS + CONT_MAX_MS) / 2;
	localparam real UNLOAD_MIN_S = 0.19;
	localparam real UNLOAD_MAX_S = 0.50;
	localparam logic [15:0] UNLOAD_MIN_MS = 16'(int'($ceil(UNLOAD_MIN_S * MS_PER_S)));
	localparam logic [15:0] UNLOAD_MAX_MS = 16'(int'($floor(UNLOAD_MAX_S * MS_PER_S)));
	localparam real GAP_INIT_S = 10.0;
	localparam logic [15:0] GAP_INIT_MS = 16'(int'(GAP_INIT_S * MS_PER_S));
	localparam int MISC_PERIOD_MIN = 30;
	localparam int MISC_MS_DEF = MISC_PERIOD_MIN * 60 * MS_PER_S;
	// Shift-out frame: select bit plus 16 data bits
	localparam logic [4:0] SH_BITS = 5'h11;
	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RUN_TIME = 8'h08;
	localparam logic [7:0] REG_GAP = 8'h0C;
	localparam logic [7:0] REG_PULSE = 8'h10;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_RESTART_BIT = 1;
	localparam int CTRL_STOP_BIT = 2;
	localparam int CTRL_CLR_BIT = 3;
	typedef enum logic [1:0] {
		MODE_ENG = 2'b00,
		MODE_SCI = 2'b01,
		MODE_SHUT = 2'b10
	} mode_t;
endpackage

// ### src/tc_decoder.sv
`timescale 1ns/10ps
module tc_decoder import rtc_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Word stream
	input wire logic [15:0] i_word,
	input wire logic i_valid,
	input wire logic i_sop,
	// Decoded commands
	output logic o_accept_rt,
	output logic o_accept_pp,
	output logic o_reject,
	output logic [15:0] o_data
);
	logic [2:0] idx_r;
	logic act_r;
	logic ok_r;
	logic [15:0] sum_r;
	logic [3:0] ack_r;
	logic [7:0] sub_r;
	logic [15:0] data_r;
	wire take = i_valid & (i_sop | act_r);
	wire [2:0] idx = i_sop ? 3'h0 : idx_r;
	wire [7:0] sub = i_word[15:8];
	wire sub_ok = (sub == SUB_RUN_TIME && ack_r == ACK_RUN_TIME) ||
		(sub == SUB_PULSE_POS && ack_r == ACK_PULSE_POS);
	wire w_ok = (idx == 3'h0) ? (i_word == HDR_ID_WORD) :
		(idx == 3'h1) ? (i_word[15:14] == SEQ_FLAGS && i_word[13:11] == SEQ_SRC_GROUND) :
		(idx == 3'h2) ? (i_word == PKT_LEN) :
		(idx == 3'h3) ? (i_word[15:12] == PUS_CHK_NIB && i_word[7:0] == PKT_TYPE) :
		(idx == 3'h4) ? (sub_ok && i_word[7:0] == PAD_BYTE) :
		(idx == 3'h5) ? 1'b1 : (i_word == sum_r);
	wire last = take & (idx == 3'(TC_WORDS - 1));
	wire good = last & ok_r & w_ok;
	wire [15:0] sum_nxt = (idx == 3'h0) ? i_word : (sum_r ^ i_word);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			idx_r <= 3'h0;
			act_r <= 1'b0;
			ok_r <= 1'b0;
			sum_r <= 16'h0000;
			ack_r <= 4'h0;
			sub_r <= 8'h00;
			data_r <= 16'h0000;
		end else if (take) begin
			idx_r <= idx + 3'h1;
			act_r <= ~last;
			ok_r <= (idx == 3'h0 ? 1'b1 : ok_r) & w_ok;
			sum_r <= sum_nxt;
			if (idx == 3'h3)
				ack_r <= i_word[11:8];
			if (idx == 3'h4)
				sub_r <= sub;
			if (idx == 3'h5)
				data_r <= i_word;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_accept_rt <= 1'b0;
			o_accept_pp <= 1'b0;
			o_reject <= 1'b0;
			o_data <= 16'h0000;
		end else begin
			o_accept_rt <= good & (sub_r == SUB_RUN_TIME);
			o_accept_pp <= good & (sub_r == SUB_PULSE_POS);
			o_reject <= last & ~(ok_r & w_ok);
			if (good)
				o_data <= data_r;
		end
	end
endmodule // tc_decoder

// ### src/spectro_runtime_ctrl.sv
`timescale 1ns/10ps
module spectro_runtime_ctrl import rtc_pkg::*; #(
	parameter int MS_CYC = MS_CYC_CLK,
	parameter int SCAN_CYC = SCAN_CYC_CLK,
	parameter int CONT_READ_MS = CONT_READ_MS_DEF,
	parameter int MISC_PERIOD_MS = MISC_MS_DEF
) (
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_NRST,
	// Telecommand word stream
	input wire logic [15:0] I_TC_WORD,
	input wire logic I_TC_VALID,
	input wire logic I_TC_SOP,
	output logic O_TC_ACCEPT,
	output logic O_TC_REJECT,
	// Register port
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [31:0] I_REG_WDATA,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	output logic [31:0] O_REG_RDATA,
	// Spectrometer
	input wire logic I_SPEC_BUSY,
	output logic O_SCAN_GATE,
	output logic O_CONT_READ,
	output logic O_SHIFT_CLK,
	output logic O_SHIFT_DATA,
	output logic O_SHIFT_LOAD,
	// Status and events
	output logic O_ERR_EVENT,
	output logic [1:0] O_MODE,
	// Miscellaneous science telemetry
	output logic O_MISC_PKT,
	output logic [15:0] O_TM_RUN_TIME,
	output logic [15:0] O_TM_GAP_MS,
	output logic O_TM_GAP_UPD
);
	function automatic logic [SCALED_W-1:0] scale_count(input logic [15:0] w);
		logic [SCALED_W-1:0] c;
		c = SCALED_W'(w[RT_CNT_W-1:0]);
		if (w[RT_SMALL_BIT])
			c = c << SMALL_SHIFT;
		if (w[RT_LARGE_BIT])
			c = c << LARGE_SHIFT;
		return c;
	endfunction

	// Command decode
	logic acc_rt;
	logic acc_pp;
	logic [15:0] cmd_data;
	tc_decoder u_dec (
		.i_clk(I_CORE_CLK),
		.i_nrst(I_NRST),
		.i_word(I_TC_WORD),
		.i_valid(I_TC_VALID),
		.i_sop(I_TC_SOP),
		.o_accept_rt(acc_rt),
		.o_accept_pp(acc_pp),
		.o_reject(O_TC_REJECT),
		.o_data(cmd_data)
	);
	assign O_TC_ACCEPT = acc_rt | acc_pp;

	// Register writes
	wire wr_ctrl = I_REG_WR & (I_REG_ADDR == REG_CTRL);
	wire soft_rst = wr_ctrl & I_REG_WDATA[CTRL_RESTART_BIT];
	wire sw_start = wr_ctrl & I_REG_WDATA[CTRL_START_BIT];
	wire sw_stop = wr_ctrl & I_REG_WDATA[CTRL_STOP_BIT];
	wire sw_clr = wr_ctrl & I_REG_WDATA[CTRL_CLR_BIT];

	mode_t mode_r;
	mode_t mode_nxt;
	logic [15:0] rt_word_r;
	logic [15:0] pp_r;
	logic [15:0] ms_div_r;
	logic [12:0] period_ms_r;
	logic [9:0] scan_div_r;
	logic [SCALED_W-1:0] scan_left_r;
	logic scan_act_r;
	logic busy_d_r;
	logic [15:0] gap_cnt_r;
	logic gap_run_r;
	logic [15:0] gap_r;
	logic gap_upd_r;
	logic [15:0] unload_ms_r;
	logic unload_run_r;
	logic fail_r;
	logic unload_err_r;
	logic [21:0] misc_ms_r;
	logic pend_rt_r;
	logic pend_pp_r;
	logic [16:0] sh_r;
	logic [4:0] sh_cnt_r;
	logic sh_act_r;

	// Timebases
	wire sci = (mode_r == MODE_SCI);
	wire ms_tick = (ms_div_r == 16'(MS_CYC - 1));
	wire scan_tick = scan_act_r & (scan_div_r == 10'(SCAN_CYC - 1));
	wire enter_sci = (mode_r == MODE_ENG) & sw_start;
	wire readout = sci & ms_tick & (period_ms_r == 13'(CONT_READ_MS - 1));
	// A stop or restart in the same cycle must not open a period
	wire period_start = (mode_nxt == MODE_SCI) & (enter_sci | (readout & ~I_SPEC_BUSY));
	wire failure = readout & I_SPEC_BUSY;
	wire busy_fall = busy_d_r & ~I_SPEC_BUSY;
	wire scan_end = scan_tick & (scan_left_r == SCALED_W'(1));
	wire [SCALED_W-1:0] next_scan = scale_count(rt_word_r);
	wire misc_due = sci & ms_tick & (misc_ms_r == 22'(MISC_PERIOD_MS - 1));
	wire gap_better = gap_run_r & (gap_cnt_r < gap_r);
	wire gap_reset = soft_rst | acc_rt;
	wire gap_take = readout & ~I_SPEC_BUSY & gap_run_r & ~soft_rst;
	wire unload_bad = unload_run_r & ((unload_ms_r < UNLOAD_MIN_MS) | (unload_ms_r > UNLOAD_MAX_MS));

	// Mode sequencing
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			MODE_ENG: if (sw_start) mode_nxt = MODE_SCI;
			MODE_SCI: if (failure | sw_stop) mode_nxt = MODE_SHUT;
			MODE_SHUT: if (~sh_act_r & ~pend_rt_r & ~pend_pp_r) mode_nxt = MODE_ENG;
			default: mode_nxt = MODE_ENG;
		endcase
		if (soft_rst)
			mode_nxt = MODE_ENG;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST)
			mode_r <= MODE_ENG;
		else
			mode_r <= mode_nxt;
	end
	assign O_MODE = mode_r;

	// Stored settings
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rt_word_r <= RT_DEFAULT;
			pp_r <= PP_DEFAULT;
		end else if (soft_rst) begin
			rt_word_r <= RT_DEFAULT;
			pp_r <= PP_DEFAULT;
		end else begin
			if (acc_rt)
				rt_word_r <= cmd_data;
			if (acc_pp)
				pp_r <= cmd_data;
		end
	end

	// Scan period timing
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ms_div_r <= 16'h0000;
			period_ms_r <= 13'h0000;
		end else if (period_start | ~sci) begin
			ms_div_r <= 16'h0000;
			period_ms_r <= 13'h0000;
		end else begin
			ms_div_r <= ms_tick ? 16'h0000 : ms_div_r + 16'h0001;
			if (ms_tick)
				period_ms_r <= period_ms_r + 13'h0001;
		end
	end

	// Integration cycle counter; count latched only at period start
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			scan_act_r <= 1'b0;
			scan_left_r <= '0;
			scan_div_r <= 10'h000;
		end else if (period_start) begin
			scan_act_r <= (next_scan != '0);
			scan_left_r <= next_scan;
			scan_div_r <= 10'h000;
		end else if (~sci | scan_end) begin
			scan_act_r <= 1'b0;
			scan_div_r <= 10'h000;
		end else if (scan_act_r) begin
			scan_div_r <= scan_tick ? 10'h000 : scan_div_r + 10'h001;
			if (scan_tick)
				scan_left_r <= scan_left_r - SCALED_W'(1);
		end
	end
	assign O_SCAN_GATE = scan_act_r;

	// Unload window and continuum gap measurement
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			busy_d_r <= 1'b0;
			unload_run_r <= 1'b0;
			unload_ms_r <= 16'h0000;
			gap_run_r <= 1'b0;
			gap_cnt_r <= 16'h0000;
		end else begin
			busy_d_r <= I_SPEC_BUSY;
			if (scan_end) begin
				unload_run_r <= 1'b1;
				unload_ms_r <= 16'h0000;
			end else if (busy_fall | period_start) begin
				unload_run_r <= 1'b0;
			end else if (unload_run_r & ms_tick & ~&unload_ms_r) begin
				unload_ms_r <= unload_ms_r + 16'h0001;
			end
			if (busy_fall) begin
				gap_run_r <= 1'b1;
				gap_cnt_r <= 16'h0000;
			end else if (period_start) begin
				gap_run_r <= 1'b0;
			end else if (gap_run_r & ms_tick & ~&gap_cnt_r) begin
				gap_cnt_r <= gap_cnt_r + 16'h0001;
			end
		end
	end

	// Smallest gap seen since the last run-time change
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			gap_r <= GAP_INIT_MS;
			gap_upd_r <= 1'b0;
		end else if (gap_take) begin
			// A fresh measurement beats a same-cycle run-time change
			if (gap_better | acc_rt)
				gap_r <= gap_cnt_r;
			gap_upd_r <= 1'b1;
		end else if (gap_reset) begin
			gap_r <= GAP_INIT_MS;
			gap_upd_r <= 1'b0;
		end
	end

	// Sticky status; a new event beats a same-cycle clear
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			fail_r <= 1'b0;
			unload_err_r <= 1'b0;
		end else begin
			fail_r <= failure | (fail_r & ~(sw_clr | soft_rst));
			unload_err_r <= (busy_fall & unload_bad) | (unload_err_r & ~(sw_clr | soft_rst));
		end
	end

	// Events and telemetry
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_ERR_EVENT <= 1'b0;
			O_CONT_READ <= 1'b0;
			O_MISC_PKT <= 1'b0;
			misc_ms_r <= 22'h000000;
			O_TM_RUN_TIME <= 16'h0000;
			O_TM_GAP_MS <= 16'h0000;
			O_TM_GAP_UPD <= 1'b0;
		end else begin
			O_ERR_EVENT <= failure;
			O_CONT_READ <= readout;
			O_MISC_PKT <= misc_due;
			if (~sci | misc_due)
				misc_ms_r <= 22'h000000;
			else if (ms_tick)
				misc_ms_r <= misc_ms_r + 22'h000001;
			if (misc_due) begin
				O_TM_RUN_TIME <= rt_word_r;
				O_TM_GAP_MS <= gap_r;
				O_TM_GAP_UPD <= gap_upd_r;
			end
		end
	end

	// Serial hand-off to the spectrometer; a command met while busy waits its turn
	wire sh_go = ~sh_act_r & (pend_rt_r | pend_pp_r);
	wire sh_last = sh_act_r & O_SHIFT_CLK & (sh_cnt_r == 5'h01);
	wire [16:0] sh_load = pend_rt_r ? {1'b0, rt_word_r} : {1'b1, pp_r};

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pend_rt_r <= 1'b0;
			pend_pp_r <= 1'b0;
		end else begin
			pend_rt_r <= acc_rt | (pend_rt_r & ~sh_go);
			pend_pp_r <= acc_pp | (pend_pp_r & ~(sh_go & ~pend_rt_r));
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			sh_act_r <= 1'b0;
			sh_r <= 17'h00000;
			sh_cnt_r <= 5'h00;
			O_SHIFT_CLK <= 1'b0;
			O_SHIFT_LOAD <= 1'b0;
		end else begin
			O_SHIFT_LOAD <= sh_last;
			if (sh_go) begin
				sh_act_r <= 1'b1;
				sh_r <= sh_load;
				sh_cnt_r <= SH_BITS;
				O_SHIFT_CLK <= 1'b0;
			end else if (sh_act_r) begin
				O_SHIFT_CLK <= ~O_SHIFT_CLK;
				if (O_SHIFT_CLK) begin
					sh_r <= {sh_r[15:0], 1'b0};
					sh_cnt_r <= sh_cnt_r - 5'h01;
				end
				if (sh_last)
					sh_act_r <= 1'b0;
			end
		end
	end
	assign O_SHIFT_DATA = sh_r[16];

	// Register readback
	wire [31:0] status_word = {25'h0000000, I_SPEC_BUSY, sh_act_r, gap_upd_r,
		unload_err_r, fail_r, mode_r};
	wire [31:0] rd_mux = (I_REG_ADDR == REG_STATUS) ? status_word :
		(I_REG_ADDR == REG_RUN_TIME) ? {16'h0000, rt_word_r} :
		(I_REG_ADDR == REG_GAP) ? {16'h0000, gap_r} :
		(I_REG_ADDR == REG_PULSE) ? {16'h0000, pp_r} : 32'h00000000;

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST)
			O_REG_RDATA <= 32'h00000000;
		else if (I_REG_RD)
			O_REG_RDATA <= rd_mux;
		else
			O_REG_RDATA <= 32'h00000000;
	end
endmodule // spectro_runtime_ctrl

// ### bench/spectro_runtime_ctrl_props.sv
`timescale 1ns/10ps
module spectro_runtime_ctrl_props import rtc_pkg::*; #(
	parameter int MS_CYC = 20000,
	parameter int CONT_READ_MS = 5000
) (
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_NRST,
	// Inputs watched
	input wire logic I_TC_VALID,
	input wire logic I_REG_RD,
	// Outputs watched
	input wire logic O_TC_ACCEPT,
	input wire logic O_TC_REJECT,
	input wire logic [31:0] O_REG_RDATA,
	input wire logic O_SCAN_GATE,
	input wire logic O_CONT_READ,
	input wire logic O_SHIFT_LOAD,
	input wire logic O_ERR_EVENT,
	input wire logic [1:0] O_MODE,
	input wire logic O_MISC_PKT
);
	localparam int READ_CYC = CONT_READ_MS * MS_CYC;
	logic gate_q_r;
	logic [31:0] since_r;
	// Cycles since the current period's gate rose
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			gate_q_r <= 1'b0;
			since_r <= 32'h0;
		end else begin
			gate_q_r <= O_SCAN_GATE;
			since_r <= (O_SCAN_GATE && !gate_q_r) ? 32'h1 : since_r + 32'h1;
		end
	end
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_NRST);
	one_answer_a: assert property (!(O_TC_ACCEPT && O_TC_REJECT)) else $error("accept with reject");
	answer_after_word_a: assert property ((O_TC_ACCEPT || O_TC_REJECT) |->
		($past(I_TC_VALID) || $past(I_TC_VALID, 2))) else $error("answer without word");
	shift_after_accept_a: assert property (O_TC_ACCEPT |-> ##[30:40] O_SHIFT_LOAD) else $error("no shift load");
	rdata_idle_a: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 32'h0) else $error("read data not idle");
	err_at_read_a: assert property (O_ERR_EVENT |-> O_CONT_READ || $past(O_CONT_READ)) else $error("stray error");
	err_shutdown_a: assert property (O_ERR_EVENT |-> ##[0:1] (O_MODE == MODE_SHUT)) else $error("no shutdown");
	err_single_a: assert property (O_ERR_EVENT |=> !O_ERR_EVENT) else $error("error event too long");
	read_timing_a: assert property (O_CONT_READ |->
		since_r >= READ_CYC - 3 && since_r <= READ_CYC + 2) else $error("readout off time");
	misc_sci_a: assert property (O_MISC_PKT |-> $past(O_MODE) == MODE_SCI) else $error("misc outside science");
	gate_sci_a: assert property ($rose(O_SCAN_GATE) |-> O_MODE == MODE_SCI) else $error("gate outside science");
	cover property (O_TC_ACCEPT);
	cover property (O_TC_REJECT);
	cover property (O_ERR_EVENT);
	cover property (O_MISC_PKT);
endmodule // spectro_runtime_ctrl_props

bind spectro_runtime_ctrl spectro_runtime_ctrl_props #(.MS_CYC(MS_CYC), .CONT_READ_MS(CONT_READ_MS)) u_props (
	.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_TC_VALID(I_TC_VALID), .I_REG_RD(I_REG_RD),
	.O_TC_ACCEPT(O_TC_ACCEPT), .O_TC_REJECT(O_TC_REJECT), .O_REG_RDATA(O_REG_RDATA),
	.O_SCAN_GATE(O_SCAN_GATE), .O_CONT_READ(O_CONT_READ), .O_SHIFT_LOAD(O_SHIFT_LOAD),
	.O_ERR_EVENT(O_ERR_EVENT), .O_MODE(O_MODE), .O_MISC_PKT(O_MISC_PKT));

// ### bench/spec_model.sv
`timescale 1ns/10ps
module spec_model #(
	parameter int UNLOAD_CYC = 20
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// From the controller
	input wire logic i_gate,
	input wire logic i_sclk,
	input wire logic i_sdata,
	input wire logic i_sload,
	// To the bench
	output logic o_busy,
	output logic [16:0] o_frame
);
	logic [31:0] hold_r;
	logic [16:0] shift_r;
	logic sclk_q_r;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_busy <= 1'b0;
			hold_r <= 32'h0;
			shift_r <= 17'h0;
			o_frame <= 17'h0;
			sclk_q_r <= 1'b0;
		end else begin
			sclk_q_r <= i_sclk;
			// Busy stays up while the data unloads after the scan
			if (i_gate) begin
				o_busy <= 1'b1;
				hold_r <= 32'(UNLOAD_CYC);
			end else if (hold_r != 32'h0) hold_r <= hold_r - 32'h1;
			else o_busy <= 1'b0;
			// Data sampled in the high phase, after it settled on the fall
			if (i_sclk && !sclk_q_r) shift_r <= {shift_r[15:0], i_sdata};
			if (i_sload) o_frame <= shift_r;
		end
	end
endmodule // spec_model

// ### bench/spectro_runtime_ctrl_bench.sv
`timescale 1ns/10ps
module spectro_runtime_ctrl_bench import rtc_pkg::*; ;
	localparam int MSC = 10;
	localparam int SCC = 2;
	localparam int CRM = 30;
	localparam int MPM = 50;
	logic clk, nrst, tc_valid, tc_sop, reg_wr, reg_rd, busy, gate, cont_read, sclk, sdata, sload;
	logic acc, rej, err, misc, tm_upd;
	logic [15:0] tc_word, tm_rt, tm_gap;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [1:0] mode;
	logic [16:0] frame;
	logic [10:0] seq = 11'h0;
	int n_errors = 0, checks_done = 0, cyc = 0, n_acc = 0, n_rej = 0, n_err = 0, g_cnt = 0, t0, a0, r0;
	int gate_len[$], misc_t[$], read_t[$];
	logic [7:0] t_sub [5] = '{SUB_PULSE_POS, SUB_PULSE_POS, 8'h0E, SUB_RUN_TIME, SUB_RUN_TIME};
	logic [3:0] t_ack [5] = '{4'h1, ACK_PULSE_POS, ACK_PULSE_POS, ACK_RUN_TIME, ACK_RUN_TIME};
	logic [15:0] t_dat [5] = '{16'h0123, 16'h01F4, 16'h0155, 16'h1234, 16'h4002};
	logic [15:0] t_flip [5] = '{16'h0, 16'h0, 16'h0, 16'h0080, 16'h0};
	logic t_ok [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

	spectro_runtime_ctrl #(.MS_CYC(MSC), .SCAN_CYC(SCC), .CONT_READ_MS(CRM), .MISC_PERIOD_MS(MPM)) u_dut (
		.I_CORE_CLK(clk), .I_NRST(nrst), .I_TC_WORD(tc_word), .I_TC_VALID(tc_valid), .I_TC_SOP(tc_sop),
		.O_TC_ACCEPT(acc), .O_TC_REJECT(rej), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
		.I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata), .I_SPEC_BUSY(busy),
		.O_SCAN_GATE(gate), .O_CONT_READ(cont_read), .O_SHIFT_CLK(sclk), .O_SHIFT_DATA(sdata),
		.O_SHIFT_LOAD(sload), .O_ERR_EVENT(err), .O_MODE(mode), .O_MISC_PKT(misc),
		.O_TM_RUN_TIME(tm_rt), .O_TM_GAP_MS(tm_gap), .O_TM_GAP_UPD(tm_upd));
	spec_model #(.UNLOAD_CYC(20)) u_spec (.i_clk(clk), .i_nrst(nrst), .i_gate(gate), .i_sclk(sclk),
		.i_sdata(sdata), .i_sload(sload), .o_busy(busy), .o_frame(frame));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic test_done();
		if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	// Sends one whole packet, then leaves room for the answer and the shift-out
	task automatic tc(input logic [7:0] sub, input logic [3:0] ack, input logic [15:0] data, input logic [15:0] flip);
		logic [15:0] w [7];
		w[0] = HDR_ID_WORD;
		w[1] = {SEQ_FLAGS, SEQ_SRC_GROUND, seq};
		w[2] = PKT_LEN;
		w[3] = {PUS_CHK_NIB, ack, PKT_TYPE};
		w[4] = {sub, PAD_BYTE};
		w[5] = data;
		w[6] = w[0] ^ w[1] ^ w[2] ^ w[3] ^ w[4] ^ w[5] ^ flip;
		seq = seq + 11'h1;
		for (int i = 0; i < TC_WORDS; i++) begin
			@(posedge clk);
			tc_valid <= 1'b1;
			tc_sop <= (i == 0);
			tc_word <= w[i];
		end
		@(posedge clk);
		tc_valid <= 1'b0;
		tc_sop <= 1'b0;
		repeat (45) @(posedge clk);
	endtask

	// Outputs sampled before the edge's own updates land
	always @(posedge clk) begin
		cyc++;
		if (acc === 1'b1) n_acc++;
		if (rej === 1'b1) n_rej++;
		if (err === 1'b1) n_err++;
		if (misc === 1'b1) misc_t.push_back(cyc);
		if (cont_read === 1'b1) read_t.push_back(cyc);
		if (gate === 1'b1) g_cnt++;
		else if (g_cnt != 0) begin
			gate_len.push_back(g_cnt);
			g_cnt = 0;
		end
		if (cyc == 8000) begin
			n_errors++;
			test_done();
		end
	end

	initial begin
		nrst = 1'b0;
		tc_word = 16'h0;
		tc_valid = 1'b0;
		tc_sop = 1'b0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rdck(REG_RUN_TIME, 32'(RT_DEFAULT));
		rdck(REG_PULSE, 32'(PP_DEFAULT));
		rdck(REG_GAP, 32'(GAP_INIT_MS));
		rdck(8'h14, 32'h0);
		rd(REG_STATUS, v);
		chk(32'(v[4:0]), 32'h0);
		for (int i = 0; i < 5; i++) begin
			a0 = n_acc;
			r0 = n_rej;
			tc(t_sub[i], t_ack[i], t_dat[i], t_flip[i]);
			chk(32'(n_acc - a0), 32'(t_ok[i]));
			chk(32'(n_rej - r0), 32'(!t_ok[i]));
			if (t_ok[i]) chk(32'(frame), {15'h0, t_sub[i] == SUB_PULSE_POS, t_dat[i]});
		end
		rdck(REG_PULSE, 32'h01F4);
		rdck(REG_RUN_TIME, 32'h4002);
		rdck(REG_GAP, 32'(GAP_INIT_MS));
		// New run time sent mid-scan must wait for the next period
		wr(REG_CTRL, 32'h1);
		#1 t0 = cyc;
		repeat (10) @(posedge clk);
		tc(SUB_RUN_TIME, ACK_RUN_TIME, 16'h0003, 16'h0);
		repeat (1100) @(posedge clk);
		chk(32'(gate_len[0]), 32'(2 * 16 * SCC));
		chk(32'(gate_len[1]), 32'(3 * SCC));
		chk(32'(read_t[0] - t0 >= CRM * MSC && read_t[0] - t0 <= CRM * MSC + 3), 32'h1);
		chk(32'(misc_t[1] - misc_t[0]), 32'(MPM * MSC));
		chk(32'(tm_rt), 32'h0003);
		chk(32'(tm_upd), 32'h1);
		// Busy falls 21 ms before the first readout, the smallest gap seen
		chk(32'(tm_gap), 32'h15);
		chk(32'(n_err), 32'h0);
		rd(REG_STATUS, v);
		chk(32'(v[1:0]), 32'(MODE_SCI));
		// Model unloads in 2 ms, far under the allowed window
		chk(32'(v[3]), 32'h1);
		wr(REG_CTRL, 32'h2);
		rdck(REG_RUN_TIME, 32'(RT_DEFAULT));
		rdck(REG_PULSE, 32'(PP_DEFAULT));
		rd(REG_STATUS, v);
		chk(32'(v[4:0]), 32'h0);
		// Default run time outlasts the readout, so busy is still up there
		wr(REG_CTRL, 32'h1);
		repeat (CRM * MSC + 20) @(posedge clk);
		chk(32'(n_err), 32'h1);
		repeat (100) @(posedge clk);
		rd(REG_STATUS, v);
		chk(32'(v[2:0]), {29'h0, 1'b1, MODE_ENG});
		test_done();
	end
endmodule // spectro_runtime_ctrl_bench
